// file: core/suel_uart_events.sv
`timescale 1ns/1ps
`include "suel_regs.svh"
// Summary of operation
// RL1 - Break end after one idle bit
// RL2 - Break flag once per break
// RL3 - Busy flag at mid stop, no buffer
// RL4 - Resume storing once buffer supplied
// RL5 - Tx flag when last char queued
// RL6 - Software waits two chars after tx flag
// RL7 - Rx flag at mid last stop bit
// RL8 - Event bits 7, 5, 3 reserved
// RL9 - Software uses disable sequence for changes
// RL10 - Disable closes buffers in use
// RL11 - Baud rate writable while running
// RL12 - Nested interrupt tracked by in-service bit
// RL13 - Software may force receive buffer closed
// RL14 - Flags sticky, masked onto interrupt
module suel_uart_events
    import suel_pkg::*;
#(
    parameter int BUF_LEN = 8  // Characters per receive buffer
)(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [15:0] rdata,
    input  wire logic        rxd,
    output logic             txd,
    output logic             irq
);

    suel_state_s s_r;    // Registered state
    suel_state_s s_nxt;  // Next state
    suel_req_s   req;    // Bundled request

    assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

    // Mask and reserved-bit filter for interrupt
    function automatic logic pending(input logic [7:0] ev,
                                     input logic [7:0] msk);
        pending = |(ev & msk & `SUEL_EV_USED);
    endfunction

    // Baud divider wrap test
    function automatic logic div_wrap(input logic [15:0] cnt,
                                      input logic [15:0] lim);
        div_wrap = (cnt >= lim);
    endfunction

    // Next-state logic for the whole block
    always_comb begin
        logic [7:0] ev_set;  // Events raised this cycle
        logic [7:0] ev_clr;  // Write-one-to-clear
        logic       rx_tk;   // Receive oversample tick
        logic       tx_tk;   // Transmit oversample tick
        logic       mid;     // Middle of a bit
        logic       close;   // Receive buffer closes
        logic       ren;
        logic       ten;
        ev_set = 8'h00;
        ev_clr = 8'h00;
        close  = 1'b0;
        s_nxt  = s_r;
        ren    = s_r.ctrl_r[`SUEL_CTRL_REN];
        ten    = s_r.ctrl_r[`SUEL_CTRL_TEN];
        s_nxt.rdata = 16'h0000;

        // Pin synchroniser, second stage alone is read
        s_nxt.rxd_m = rxd;
        s_nxt.rxd_s = s_r.rxd_m;

        // Baud dividers; a new divisor is compared at once, in the period in progress
        rx_tk = div_wrap(s_r.rx_div, s_r.baud_r);
        tx_tk = div_wrap(s_r.tx_div, s_r.baud_r);
        s_nxt.rx_div = rx_tk ? 16'h0000 : s_r.rx_div + 16'h0001;
        s_nxt.tx_div = tx_tk ? 16'h0000 : s_r.tx_div + 16'h0001;
        mid = rx_tk && (s_r.rx_tick == `SUEL_MID_TICK);

        // Receive engine
        if (rx_tk) begin
            s_nxt.rx_tick = s_r.rx_tick + 4'h1;
        end
        case (s_r.rx_st)
            RX_IDLE: begin
                // Low line level begins a start bit
                if (ren && !s_r.rxd_s) begin
                    s_nxt.rx_st   = RX_START;
                    s_nxt.rx_tick = 4'h0;
                end
            end
            RX_START: begin
                if (mid) begin
                    s_nxt.rx_st   = s_r.rxd_s ? RX_IDLE : RX_DATA;
                    s_nxt.rx_tick = 4'h8;
                    s_nxt.rx_bit  = 3'h0;
                end
            end
            RX_DATA: begin
                if (mid) begin
                    s_nxt.rx_sh  = {s_r.rxd_s, s_r.rx_sh[7:1]};
                    s_nxt.rx_bit = s_r.rx_bit + 3'h1;
                    if (s_r.rx_bit == 3'h7) begin
                        s_nxt.rx_st = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                // Decisions are taken at the middle of the stop bit
                if (mid) begin
                    s_nxt.rx_st = RX_IDLE;
                    if (!s_r.rxd_s && s_r.rx_sh == 8'h00) begin
                        // RL2 once per break
                        if (!s_r.brk_seen) begin
                            ev_set[`SUEL_EV_BRK] = 1'b1;
                        end
                        s_nxt.brk_seen = 1'b1;
                        s_nxt.rx_st    = RX_BREAK;
                    end else if (!s_r.rx_open &&
                                 s_r.rx_free == 4'h0) begin
                        // RL3 first dropped character only
                        if (!s_r.rx_dropping) begin
                            ev_set[`SUEL_EV_BSY] = 1'b1;
                        end
                        s_nxt.rx_dropping = 1'b1;
                    end else begin
                        // RL4 store into available buffer
                        s_nxt.rx_dropping = 1'b0;
                        s_nxt.rx_data_r   = s_r.rx_sh;
                        s_nxt.rx_cnt      = s_r.rx_cnt + 8'h01;
                        if (!s_r.rx_open) begin
                            s_nxt.rx_open = 1'b1;
                            s_nxt.rx_free = s_r.rx_free - 4'h1;
                            s_nxt.rx_cnt  = 8'h01;
                        end
                        // RL7 close at mid last stop bit
                        if (s_r.rx_open && s_r.rx_cnt ==
                            8'(BUF_LEN - 1)) begin
                            close = 1'b1;
                        end
                    end
                end
            end
            RX_BREAK: begin
                // RL1 end flagged after one idle bit
                if (!s_r.rxd_s) begin
                    s_nxt.rx_tick = 4'h0;
                end else if (rx_tk && s_r.rx_tick == `SUEL_LAST_TICK) begin
                    ev_set[`SUEL_EV_BREAK_END_FLAG] = 1'b1;
                    s_nxt.brk_seen = 1'b0;
                    s_nxt.rx_st    = RX_IDLE;
                end
            end
            default: s_nxt.rx_st = RX_IDLE;
        endcase

        // Transmit engine
        if (tx_tk) begin
            s_nxt.tx_tick = s_r.tx_tick + 4'h1;
        end
        case (s_r.tx_st)
            TX_IDLE: begin
                s_nxt.txd = 1'b1;
                if (ten && s_r.tx_q_full && tx_tk) begin
                    s_nxt.tx_sh     = s_r.tx_q;
                    s_nxt.tx_q_full = 1'b0;
                    s_nxt.tx_tick   = 4'h0;
                    s_nxt.txd       = 1'b0;
                    s_nxt.tx_st     = TX_START;
                end
            end
            TX_START: begin
                if (tx_tk && s_r.tx_tick == `SUEL_LAST_TICK) begin
                    s_nxt.txd    = s_r.tx_sh[0];
                    s_nxt.tx_bit = 3'h0;
                    s_nxt.tx_st  = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_tk && s_r.tx_tick == `SUEL_LAST_TICK) begin
                    s_nxt.tx_sh  = {1'b1, s_r.tx_sh[7:1]};
                    s_nxt.txd    = s_r.tx_sh[1];
                    s_nxt.tx_bit = s_r.tx_bit + 3'h1;
                    if (s_r.tx_bit == 3'h7) begin
                        s_nxt.txd   = 1'b1;
                        s_nxt.tx_st = TX_STOP;
                    end
                end
            end
            TX_STOP: begin
                if (tx_tk && s_r.tx_tick == `SUEL_LAST_TICK) begin
                    s_nxt.tx_st = TX_IDLE;
                end
            end
            default: s_nxt.tx_st = TX_IDLE;
        endcase

        // Register reads, data one cycle later
        if (req.rd) begin
            case (req.addr)
                `SUEL_OFF_EVENT:  s_nxt.rdata = {8'h00, s_r.event_r};
                `SUEL_OFF_MASK:   s_nxt.rdata = {8'h00, s_r.mask_r};
                `SUEL_OFF_CTRL:   s_nxt.rdata = {14'h0000, s_r.ctrl_r};
                `SUEL_OFF_BAUD:   s_nxt.rdata = s_r.baud_r;
                `SUEL_OFF_STATUS: s_nxt.rdata = {12'h000,
                    s_r.tx_st != TX_IDLE, s_r.tx_q_full,
                    s_r.rx_dropping, s_r.rx_open};
                `SUEL_OFF_RXFREE: s_nxt.rdata = {12'h000, s_r.rx_free};
                `SUEL_OFF_TXLEN:  s_nxt.rdata = {8'h00, s_r.tx_left};
                `SUEL_OFF_RXDATA: s_nxt.rdata = {8'h00, s_r.rx_data_r};
                `SUEL_OFF_RXLEN:  s_nxt.rdata = {8'h00, s_r.rx_len_r};
                `SUEL_OFF_INSVC:  s_nxt.rdata = {15'h0000, s_r.insvc};
                default:          s_nxt.rdata = 16'h0000;
            endcase
        end

        // Register writes
        if (req.wr) begin
            case (req.addr)
                `SUEL_OFF_EVENT: ev_clr = req.wdata[7:0];
                `SUEL_OFF_MASK:  s_nxt.mask_r = req.wdata[7:0];
                `SUEL_OFF_CTRL:  s_nxt.ctrl_r = req.wdata[1:0];
                // RL11 baud writable while running
                `SUEL_OFF_BAUD:  s_nxt.baud_r = req.wdata;
                `SUEL_OFF_RXFREE: begin
                    // RL4 supplying a buffer; dropping ends at the next stored char
                    if (s_r.rx_free != 4'hF) begin
                        s_nxt.rx_free = s_r.rx_free + 4'h1;
                    end
                end
                `SUEL_OFF_TXLEN: begin
                    s_nxt.tx_left = req.wdata[7:0];
                    s_nxt.tx_open = (req.wdata[7:0] != 8'h00);
                end
                `SUEL_OFF_TXDATA: begin
                    // Writes while the queue is full are ignored
                    if (s_r.tx_open && !s_r.tx_q_full) begin
                        s_nxt.tx_q      = req.wdata[7:0];
                        s_nxt.tx_q_full = 1'b1;
                        s_nxt.tx_left   = s_r.tx_left - 8'h01;
                        // RL5 flag when last char queued
                        if (s_r.tx_left == 8'h01) begin
                            ev_set[`SUEL_EV_TX] = 1'b1;
                            s_nxt.tx_open = 1'b0;
                        end
                    end
                end
                `SUEL_OFF_INSVC: begin
                    // RL12 in-service cleared by writing one
                    if (req.wdata[0]) begin
                        s_nxt.insvc = 1'b0;
                    end
                end
                `SUEL_OFF_CMD: begin
                    if (req.wdata[7:0] == `SUEL_CMD_CLOSE_RX &&
                        s_r.rx_open) begin
                        close = 1'b1;
                    end else if (req.wdata[7:0] == `SUEL_CMD_DISABLE) begin
                        // RL10 close buffers in use
                        s_nxt.ctrl_r  = 2'b00;
                        s_nxt.tx_open = 1'b0;
                        s_nxt.tx_left = 8'h00;
                        s_nxt.tx_q_full = 1'b0;
                        s_nxt.rx_st   = RX_IDLE;
                        s_nxt.tx_st   = TX_IDLE;
                        s_nxt.txd     = 1'b1;
                        if (s_r.rx_open) begin
                            close = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end

        // Receive buffer close reports its length
        if (close) begin
            ev_set[`SUEL_EV_RX] = 1'b1;
            s_nxt.rx_open  = 1'b0;
            s_nxt.rx_len_r = s_nxt.rx_cnt;
        end

        // RL14 sticky flags, set wins over clear
        // RL8 reserved bits never set
        s_nxt.event_r = ((s_r.event_r & ~ev_clr) | ev_set)
                        & `SUEL_EV_USED;

        // RL12 in-service raised on acceptance outside service: event read while pending
        if (pending(s_r.event_r, s_r.mask_r) && !s_r.insvc &&
            req.rd && req.addr == `SUEL_OFF_EVENT) begin
            s_nxt.insvc = 1'b1;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_r        <= '0;
            s_r.rxd_m  <= 1'b1;
            s_r.rxd_s  <= 1'b1;
            s_r.txd    <= 1'b1;
            s_r.baud_r <= `SUEL_BAUD_RST;
            s_r.rx_st  <= RX_IDLE;
            s_r.tx_st  <= TX_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // rdata and txd from flip-flops; irq combinational from event_r and mask_r
    assign rdata = s_r.rdata;
    assign txd   = s_r.txd;
    // RL14 masked interrupt output
    assign irq   = pending(s_r.event_r, s_r.mask_r);

endmodule

// file: core/suel_regs.svh
`ifndef SUEL_REGS_SVH
`define SUEL_REGS_SVH

// Register offsets on the plain register port
`define SUEL_ADDR_W        4
`define SUEL_OFF_EVENT     4'h0
`define SUEL_OFF_MASK      4'h1
`define SUEL_OFF_CTRL      4'h2
`define SUEL_OFF_BAUD      4'h3
`define SUEL_OFF_CMD       4'h4
`define SUEL_OFF_STATUS    4'h5
`define SUEL_OFF_RXFREE    4'h6
`define SUEL_OFF_TXLEN     4'h7
`define SUEL_OFF_RXDATA    4'h8
`define SUEL_OFF_TXDATA    4'h9
`define SUEL_OFF_RXLEN     4'hA
`define SUEL_OFF_INSVC     4'hB

// Event flag bit positions; 7, 5 and 3 stay reserved
`define SUEL_EV_RX         0
`define SUEL_EV_TX         1
`define SUEL_EV_BSY        2
`define SUEL_EV_BRK        4
`define SUEL_EV_BREAK_END_FLAG       6
`define SUEL_EV_USED       8'h57

// Control bits
`define SUEL_CTRL_REN      0
`define SUEL_CTRL_TEN      1

// Command codes
`define SUEL_CMD_CLOSE_RX  8'h01
`define SUEL_CMD_DISABLE   8'h02

// Reset values
`define SUEL_BAUD_RST      16'h000A
`define SUEL_BUF_LEN_RST   8'h08

// Oversampling: sixteen ticks per bit
`define SUEL_OVS           16
`define SUEL_MID_TICK      4'h7
`define SUEL_LAST_TICK     4'hF

`endif

// file: core/suel_pkg.sv
package suel_pkg;

    // Receive bit engine states
    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP,
        RX_BREAK
    } suel_rx_e;

    // Transmit bit engine states
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_STOP
    } suel_tx_e;

    // Register port request bundle
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } suel_req_s;

    // Whole block state
    typedef struct packed {
        suel_rx_e    rx_st;
        suel_tx_e    tx_st;
        logic        rxd_m;
        logic        rxd_s;
        logic [15:0] rx_div;
        logic [3:0]  rx_tick;
        logic [2:0]  rx_bit;
        logic [7:0]  rx_sh;
        logic        brk_seen;
        logic        rx_dropping;
        logic [15:0] tx_div;
        logic [3:0]  tx_tick;
        logic [2:0]  tx_bit;
        logic [7:0]  tx_sh;
        logic        txd;
        logic [7:0]  tx_q;
        logic        tx_q_full;
        logic [7:0]  tx_left;
        logic        tx_open;
        logic [7:0]  event_r;
        logic [7:0]  mask_r;
        logic [1:0]  ctrl_r;
        logic [15:0] baud_r;
        logic [3:0]  rx_free;
        logic        rx_open;
        logic [7:0]  rx_cnt;
        logic [7:0]  rx_last;
        logic [7:0]  rx_len_r;
        logic [7:0]  rx_data_r;
        logic        insvc;
        logic [15:0] rdata;
    } suel_state_s;

endpackage

// file: bench/suel_uart_events_chk.sv
`timescale 1ns/1ps
`include "suel_regs.svh"
module suel_uart_events_chk
    import suel_pkg::*;
#(
    parameter int BUF_LEN = 8  // Chars per rx buffer
)(
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [15:0] rdata,
    input wire logic        rxd,
    input wire logic        txd,
    input wire logic        irq
);
    logic [7:0]  msk_r;   // Mask as software wrote it
    logic [15:0] baud_r;  // Divider as software wrote it
    logic        isv_r;   // Expected in-service bit

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Shadows of the write port; disable leaves them alone
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            msk_r  <= 8'h00;
            baud_r <= `SUEL_BAUD_RST;
            isv_r  <= 1'b0;
        end else begin
            if (wr_stb && addr == `SUEL_OFF_MASK)
                msk_r <= wdata[7:0];
            if (wr_stb && addr == `SUEL_OFF_BAUD)
                baud_r <= wdata;
            // Read while pending marks service
            if (rd_stb && addr == `SUEL_OFF_EVENT && irq)
                isv_r <= 1'b1;
            else if (wr_stb && addr == `SUEL_OFF_INSVC && wdata[0])
                isv_r <= 1'b0;
        end
    end

    // Event read, and the same read with irq pending
    sequence ev_rd;
        rd_stb && addr == `SUEL_OFF_EVENT;
    endsequence
    sequence irq_rd;
        ev_rd ##0 irq;
    endsequence

    rsv_bits_a: assert property (
        ev_rd |=> (rdata & 16'hFFA8) == 16'h0)
        else $error("reserved event bit set");
    irq_cause_a: assert property (
        irq_rd |=> (rdata[7:0] & $past(msk_r) & `SUEL_EV_USED) != 8'h0)
        else $error("irq without unmasked event");
    irq_mask_a: assert property (
        irq |-> (msk_r & `SUEL_EV_USED) != 8'h0)
        else $error("irq while all masked");
    irq_hold_a: assert property (
        $fell(irq) |-> $past(wr_stb) && $past(addr) <= 4'h1)
        else $error("irq dropped without clear");
    insvc_track_a: assert property (
        rd_stb && addr == `SUEL_OFF_INSVC |=> rdata[0] == $past(isv_r))
        else $error("in-service bit wrong");
    baud_back_a: assert property (
        rd_stb && addr == `SUEL_OFF_BAUD |=> rdata == $past(baud_r))
        else $error("baud readback wrong");
    mask_back_a: assert property (
        rd_stb && addr == `SUEL_OFF_MASK |=> rdata[7:0] == $past(msk_r))
        else $error("mask readback wrong");
    rd_idle_a: assert property (
        !rd_stb |=> rdata == 16'h0)
        else $error("read data outside read cycle");
    // Disable abandons the transmit side, so the pin must idle high
    dis_txd_a: assert property (
        wr_stb && addr == `SUEL_OFF_CMD &&
        wdata[7:0] == `SUEL_CMD_DISABLE |=> txd)
        else $error("txd not idle after disable");
endmodule

bind suel_uart_events suel_uart_events_chk #(.BUF_LEN(BUF_LEN)) u_chk (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .rxd(rxd), .txd(txd), .irq(irq));

// file: bench/suel_peer.sv
`timescale 1ns/1ps
// Far serial station: drives rxd, decodes txd
module suel_peer #(
    parameter int BIT = 32  // mclk cycles per bit
)(
    input  wire logic mclk,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] got [$];  // Characters seen on txd
    logic [7:0] sh;       // Decode shift

    initial rxd = 1'b1;  // Line idles high

    // Hold the line at one level for n cycles
    task automatic line(input logic v, input int n);
        @(posedge mclk);
        rxd <= v;
        repeat (n - 1) @(posedge mclk);
    endtask

    // One 8N1 frame, lsb first
    task automatic send(input logic [7:0] c);
        line(1'b0, BIT);
        for (int i = 0; i < 8; i++) begin
            line(c[i], BIT);
        end
        line(1'b1, BIT);
    endtask

    // Mid-bit sampling tolerates the divider's phase
    always begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge mclk);
            sh[i] = txd;
        end
        repeat (BIT) @(posedge mclk);
        // Bad stop bit: frame dropped
        if (txd)
            got.push_back(sh);
    end
endmodule

// file: bench/suel_uart_events_test.sv
`timescale 1ns/1ps
`include "suel_regs.svh"
module suel_uart_events_test;
    localparam int BIT = 32;  // mclk per bit at divider 1
    logic        mclk;
    logic        resetn;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [15:0] rdata;
    logic        rxd;
    logic        txd;
    logic        irq;
    logic [15:0] d;         // Last read data
    int          n_fail;    // Mismatches
    int          checks;    // Comparisons
    logic [35:0] rows [5];  // Address, write data, readback

    // Two-char buffers keep the run short
    suel_uart_events #(.BUF_LEN(2)) u_dut (
        .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .rxd(rxd), .txd(txd), .irq(irq));
    suel_peer #(.BIT(BIT)) u_peer (.mclk(mclk), .txd(txd), .rxd(rxd));

    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] g, e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        addr   <= a;
        wdata  <= v;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    // Read; data stands in the next cycle only
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] m, e);
        rd(a);
        chk(d & m, e);
    endtask
    task automatic ev(input logic [15:0] m, e);
        rdc(`SUEL_OFF_EVENT, m, e);
    endtask
    // Sampled once the edge has settled
    task automatic ck_irq(input logic e);
        #1 chk({15'h0, irq}, {15'h0, e});
    endtask
    // Bounded poll; running out counts as a mismatch
    task automatic poll(input logic [3:0] a, input logic [15:0] m, e);
        for (int i = 0; i < 100; i++) begin
            rd(a);
            if ((d & m) === e)
                return;
        end
        chk(d & m, e);
        results();
    endtask
    task automatic results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        addr   = 4'h0;
        wdata  = 16'h0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        n_fail = 0;
        checks = 0;
        rows = '{{`SUEL_OFF_CTRL, 16'h3, 16'h3},
                 {`SUEL_OFF_BAUD, 16'h1, 16'h1},
                 {`SUEL_OFF_MASK, 16'h57, 16'h57},
                 {4'hC, 16'h1234, 16'h0},
                 {`SUEL_OFF_EVENT, 16'hFF, 16'h0}};
        repeat (6) @(posedge mclk);
        chk({14'h0, txd, irq}, 16'h2);
        chk(rdata, 16'h0);
        resetn <= 1'b1;
        rdc(`SUEL_OFF_BAUD, 16'hFFFF, `SUEL_BAUD_RST);
        ev(16'hFFFF, 16'h0);
        // Baud rewritten while enabled; unmapped reads zero
        foreach (rows[i]) begin
            wr(rows[i][35:32], rows[i][31:16]);
            rdc(rows[i][35:32], 16'hFFFF, rows[i][15:0]);
        end
        // Buffer closes on its second char only
        wr(`SUEL_OFF_RXFREE, 16'h1);
        u_peer.send(8'hA5);
        ev(16'h1, 16'h0);
        ck_irq(1'b0);
        u_peer.send(8'h3C);
        ck_irq(1'b1);
        ev(16'h1, 16'h1);
        rdc(`SUEL_OFF_RXLEN, 16'hFFFF, 16'h2);
        rdc(`SUEL_OFF_INSVC, 16'h1, 16'h1);
        wr(`SUEL_OFF_INSVC, 16'h1);
        rdc(`SUEL_OFF_INSVC, 16'h1, 16'h0);
        wr(`SUEL_OFF_EVENT, 16'h1);
        ck_irq(1'b0);
        // No free buffer: char dropped, then storing resumes
        u_peer.send(8'h11);
        ev(16'h4, 16'h4);
        rdc(`SUEL_OFF_RXDATA, 16'hFFFF, 16'h3C);
        wr(`SUEL_OFF_RXFREE, 16'h1);
        u_peer.send(8'h22);
        rdc(`SUEL_OFF_RXDATA, 16'hFFFF, 16'h22);
        wr(`SUEL_OFF_CMD, 16'h1);
        ev(16'h1, 16'h1);
        rdc(`SUEL_OFF_RXLEN, 16'hFFFF, 16'h1);
        wr(`SUEL_OFF_EVENT, 16'hFF);
        // Disable mid-buffer, re-enable into a fresh one
        wr(`SUEL_OFF_RXFREE, 16'h1);
        wr(`SUEL_OFF_RXFREE, 16'h1);
        u_peer.send(8'h33);
        wr(`SUEL_OFF_CMD, 16'h2);
        ev(16'h1, 16'h1);
        rdc(`SUEL_OFF_RXLEN, 16'hFFFF, 16'h1);
        rdc(`SUEL_OFF_CTRL, 16'hFFFF, 16'h0);
        wr(`SUEL_OFF_CTRL, 16'h3);
        u_peer.send(8'h44);
        u_peer.send(8'h55);
        rdc(`SUEL_OFF_RXLEN, 16'hFFFF, 16'h2);
        rdc(`SUEL_OFF_STATUS, 16'h1, 16'h0);
        wr(`SUEL_OFF_EVENT, 16'hFF);
        // Long break: one flag; end only after an idle bit
        u_peer.line(1'b0, 25 * BIT);
        ev(16'h50, 16'h10);
        wr(`SUEL_OFF_EVENT, 16'h10);
        u_peer.line(1'b0, 25 * BIT);
        ev(16'h50, 16'h0);
        u_peer.line(1'b1, 8);
        ev(16'h40, 16'h0);
        u_peer.line(1'b1, 3 * BIT);
        ev(16'h40, 16'h40);
        wr(`SUEL_OFF_MASK, 16'h0);
        ck_irq(1'b0);
        ev(16'h40, 16'h40);
        wr(`SUEL_OFF_MASK, 16'h57);
        ck_irq(1'b1);
        wr(`SUEL_OFF_EVENT, 16'hFF);
        // Two-char transmit: flag on last queue write
        wr(`SUEL_OFF_TXLEN, 16'h2);
        wr(`SUEL_OFF_TXDATA, 16'h5A);
        ev(16'h2, 16'h0);
        poll(`SUEL_OFF_STATUS, 16'h4, 16'h0);
        wr(`SUEL_OFF_TXDATA, 16'hC3);
        ev(16'h2, 16'h2);
        chk(16'(u_peer.got.size()), 16'h0);
        repeat (22 * BIT) @(posedge mclk);
        chk(16'(u_peer.got.size()), 16'h2);
        chk({8'h0, u_peer.got[0]}, 16'h5A);
        chk({8'h0, u_peer.got[1]}, 16'hC3);
        results();
    end
endmodule
